//--- jlps_pkg.sv
/*
 Constants for the link parameter and status register slice: register
 indices, field positions, reset values and comma codes.
 Assumes an APB slave that places each register at byte address 4 * index.
*/
// Function
// - the programmed 8-bit link identifier is sent as the device ID in the second ILA multiframe.
// - end-of-frame select 0 gives K28.7, 1 gives K28.1, 2 gives K28.5, and 3 is reserved.
// - status bit 6 is high while the link is up and low otherwise.
// - status bit 5 follows the sync level: 0 while sync is asserted, 1 while deasserted.
// - status bit 4 is set whenever SYSREF shifts the block, frame or multiframe clock phase.
// - writing a 1 to status bit 4 or bit 3 clears that flag.
// - status bit 3 is set by the first SYSREF event after the encoder is enabled.
// - status bit 2 is high while the SerDes PLL is locked.
// - status bit 0 is high while the converter PLL is locked.
package jlps_pkg;
   // register indices; byte address is index * 4
   localparam logic [9:0] LINK_ID_IDX = 10'h206;
   localparam logic [9:0] EOF_SEL_IDX = 10'h207;
   localparam logic [9:0] STATUS_IDX = 10'h208;
   localparam logic [9:0] CTRL_IDX = 10'h218;
   localparam logic [9:0] IMASK_IDX = 10'h219;
   localparam int ADDR_W = 12;
   // status field positions
   localparam int ST_LINK_UP = 6;
   localparam int ST_SYNC = 5;
   localparam int ST_REALIGNED = 4;
   localparam int ST_MULTIFRAME_PHASE_SET = 3;
   localparam int ST_SPLL = 2;
   localparam int ST_CPLL = 0;
   // control field positions
   localparam int CTRL_ENC_EN = 0;
   localparam int CTRL_8B10B = 1;
   // reset values
   localparam logic [7:0] LINK_ID_RST = 8'h00;
   localparam logic [7:0] EOF_SEL_RST = 8'h00;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [1:0] IMASK_RST = 2'h0;
   // end-of-frame select codes and comma characters
   localparam logic [1:0] SEL_K28_7 = 2'h0;
   localparam logic [1:0] SEL_K28_1 = 2'h1;
   localparam logic [1:0] SEL_K28_5 = 2'h2;
   localparam logic [7:0] K28_7 = 8'hFC;
   localparam logic [7:0] K28_1 = 8'h3C;
   localparam logic [7:0] K28_5 = 8'hBC;
   // ila multiframe index that carries the device id (second one)
   localparam logic [1:0] ILA_DID_MF = 2'h1;
endpackage

//--- jlps_link_if.sv
/*
 Configuration carried from the register slice to the transmit-side
 character generator. Both ends run on the same clock.
*/
`timescale 1ns/100ps
interface jlps_link_if;
   logic [7:0] link_identifier;
   logic [1:0] frame_end_char_sel;
   logic link_encoder_enable;
   logic mode_8b10b;
   modport regs (output link_identifier, output frame_end_char_sel,
                 output link_encoder_enable, output mode_8b10b);
   modport tx (input link_identifier, input frame_end_char_sel,
               input link_encoder_enable, input mode_8b10b);
endinterface

//--- jlps_char_gen.sv
/*
 Turns the link configuration into the end-of-frame comma and the ILA
 device id byte. Assumes lane logic on the same clock marks ILA slots.
*/
`timescale 1ns/100ps
module jlps_char_gen (
   input wire logic clk,
   input wire logic rst_n,
   jlps_link_if.tx cfg,
   input wire logic [1:0] ila_mf_idx,
   input wire logic ila_did_slot,
   output logic [7:0] eof_char,
   output logic eof_insert_en,
   output logic [7:0] ila_did,
   output logic ila_did_valid
);
   typedef struct packed {
      logic [7:0] eof_char;
      logic eof_insert_en;
      logic [7:0] ila_did;
      logic ila_did_valid;
   } jlps_cg_st_t;

   jlps_cg_st_t st_ff;
   jlps_cg_st_t nxt_st;

   // comma selection and id placement
   always_comb begin
      nxt_st = st_ff;
      case (cfg.frame_end_char_sel)
         jlps_pkg::SEL_K28_7: nxt_st.eof_char = jlps_pkg::K28_7;
         jlps_pkg::SEL_K28_1: nxt_st.eof_char = jlps_pkg::K28_1;
         jlps_pkg::SEL_K28_5: nxt_st.eof_char = jlps_pkg::K28_5;
         default: nxt_st.eof_char = jlps_pkg::K28_7;
      endcase
      // reserved code and 64b/66b modes never insert a comma
      nxt_st.eof_insert_en = cfg.link_encoder_enable & cfg.mode_8b10b &
                             (cfg.frame_end_char_sel != 2'h3);
      nxt_st.ila_did = cfg.link_identifier;
      nxt_st.ila_did_valid = cfg.link_encoder_enable & ila_did_slot &
                             (ila_mf_idx == jlps_pkg::ILA_DID_MF);
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign eof_char = st_ff.eof_char;
   assign eof_insert_en = st_ff.eof_insert_en;
   assign ila_did = st_ff.ila_did;
   assign ila_did_valid = st_ff.ila_did_valid;
endmodule // jlps_char_gen

//--- jlps_regs.sv
/*
 Link parameter and status register slice with an APB slave, sticky
 alignment flags, an interrupt output and the end-of-frame character
 generator. Assumes one clock; sync and pll lock pins are asynchronous,
 sysref and link-up indications come from logic on the same clock.
*/
`timescale 1ns/100ps
module jlps_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sync_n_pin,
   input wire logic serdes_pll_lock_pin,
   input wire logic converter_pll_lock_pin,
   input wire logic link_up,
   input wire logic sysref_event,
   input wire logic sysref_phase_shift,
   input wire logic [1:0] ila_mf_idx,
   input wire logic ila_did_slot,
   output logic irq,
   output logic link_encoder_enable,
   output logic mode_8b10b,
   output logic [7:0] eof_char,
   output logic eof_insert_en,
   output logic [7:0] ila_did,
   output logic ila_did_valid
);
   typedef struct packed {
      logic [7:0] link_identifier;
      logic [7:0] eof_sel;
      logic enc_en;
      logic mode_8b10b;
      logic realigned;
      logic multiframe_phase_set;
      logic armed;
      logic [1:0] imask;
      logic sync_s1;
      logic sync_s2;
      logic spll_s1;
      logic spll_s2;
      logic cpll_s1;
      logic cpll_s2;
      logic irq;
      logic [31:0] rdata;
      logic slverr;
   } jlps_regs_st_t;

   jlps_regs_st_t st_ff;
   jlps_regs_st_t nxt_st;
   jlps_link_if link_cfg ();

   // byte address of a register index
   function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
      hit = (addr == {idx, 2'b00});
   endfunction

   // live and sticky bits as software sees them
   function automatic logic [7:0] status_word(input jlps_regs_st_t s, input logic up);
      logic [7:0] w;
      w = 8'h00;
      w[jlps_pkg::ST_LINK_UP] = up;
      w[jlps_pkg::ST_SYNC] = s.sync_s2;
      w[jlps_pkg::ST_REALIGNED] = s.realigned;
      w[jlps_pkg::ST_MULTIFRAME_PHASE_SET] = s.multiframe_phase_set;
      w[jlps_pkg::ST_SPLL] = s.spll_s2;
      w[jlps_pkg::ST_CPLL] = s.cpll_s2;
      status_word = w;
   endfunction

   logic setup_ph;
   logic wr_acc;
   logic clr_realigned;
   logic clr_multiframe_phase_set;
   logic enc_rise;

   // apb phases; writes land at the access edge only
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;

   // write-one-to-clear strobes for the two sticky flags
   assign clr_realigned = wr_acc & hit(paddr, jlps_pkg::STATUS_IDX) &
                          pwdata[jlps_pkg::ST_REALIGNED];
   assign clr_multiframe_phase_set = wr_acc & hit(paddr, jlps_pkg::STATUS_IDX) &
                        pwdata[jlps_pkg::ST_MULTIFRAME_PHASE_SET];

   // encoder enable going from 0 to 1 on this write
   assign enc_rise = wr_acc & hit(paddr, jlps_pkg::CTRL_IDX) &
                     pwdata[jlps_pkg::CTRL_ENC_EN] & ~st_ff.enc_en;

   // next-state logic for the whole slice
   always_comb begin
      nxt_st = st_ff;

      // two-flop synchronisers; only the second stage is read
      nxt_st.sync_s1 = sync_n_pin;
      nxt_st.sync_s2 = st_ff.sync_s1;
      nxt_st.spll_s1 = serdes_pll_lock_pin;
      nxt_st.spll_s2 = st_ff.spll_s1;
      nxt_st.cpll_s1 = converter_pll_lock_pin;
      nxt_st.cpll_s2 = st_ff.cpll_s1;

      // plain read/write registers; no lock while enabled,
      // software is trusted to change these only when idle
      if (wr_acc && hit(paddr, jlps_pkg::LINK_ID_IDX)) begin
         nxt_st.link_identifier = pwdata[7:0];
      end
      if (wr_acc && hit(paddr, jlps_pkg::EOF_SEL_IDX)) begin
         nxt_st.eof_sel = pwdata[7:0];
      end
      if (wr_acc && hit(paddr, jlps_pkg::CTRL_IDX)) begin
         nxt_st.enc_en = pwdata[jlps_pkg::CTRL_ENC_EN];
         nxt_st.mode_8b10b = pwdata[jlps_pkg::CTRL_8B10B];
      end
      if (wr_acc && hit(paddr, jlps_pkg::IMASK_IDX)) begin
         nxt_st.imask = {pwdata[jlps_pkg::ST_REALIGNED], pwdata[jlps_pkg::ST_MULTIFRAME_PHASE_SET]};
      end

      // arm on enable, disarm on first sysref or on disable
      if (enc_rise) begin
         nxt_st.armed = 1'b1;
      end else if (!st_ff.enc_en || sysref_event) begin
         nxt_st.armed = 1'b0;
      end

      // sticky flags: a set in the clearing cycle wins
      nxt_st.realigned = (st_ff.realigned & ~clr_realigned) | sysref_phase_shift;
      nxt_st.multiframe_phase_set = (st_ff.multiframe_phase_set & ~clr_multiframe_phase_set) |
                       (sysref_event & st_ff.armed & st_ff.enc_en);

      // level interrupt from unmasked sticky flags
      nxt_st.irq = |({nxt_st.realigned, nxt_st.multiframe_phase_set} & nxt_st.imask);

      // read data and error are captured in setup, shown in access
      if (setup_ph) begin
         nxt_st.slverr = 1'b0;
         if (hit(paddr, jlps_pkg::LINK_ID_IDX)) begin
            nxt_st.rdata = {24'h000000, st_ff.link_identifier};
         end else if (hit(paddr, jlps_pkg::EOF_SEL_IDX)) begin
            nxt_st.rdata = {24'h000000, st_ff.eof_sel};
         end else if (hit(paddr, jlps_pkg::STATUS_IDX)) begin
            nxt_st.rdata = {24'h000000, status_word(st_ff, link_up)};
         end else if (hit(paddr, jlps_pkg::CTRL_IDX)) begin
            nxt_st.rdata = {30'h00000000, st_ff.mode_8b10b, st_ff.enc_en};
         end else if (hit(paddr, jlps_pkg::IMASK_IDX)) begin
            nxt_st.rdata = 32'h00000000;
            nxt_st.rdata[jlps_pkg::ST_REALIGNED] = st_ff.imask[1];
            nxt_st.rdata[jlps_pkg::ST_MULTIFRAME_PHASE_SET] = st_ff.imask[0];
         end else begin
            // unmapped: read zero and flag an error
            nxt_st.rdata = 32'h00000000;
            nxt_st.slverr = 1'b1;
         end
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.link_identifier <= jlps_pkg::LINK_ID_RST;
         st_ff.eof_sel <= jlps_pkg::EOF_SEL_RST;
         {st_ff.mode_8b10b, st_ff.enc_en} <= jlps_pkg::CTRL_RST;
         st_ff.imask <= jlps_pkg::IMASK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // zero-wait slave: ready in every access cycle
   assign pready = psel & penable;
   assign prdata = st_ff.rdata;
   assign pslverr = psel & penable & st_ff.slverr;
   assign irq = st_ff.irq;
   assign link_encoder_enable = st_ff.enc_en;
   assign mode_8b10b = st_ff.mode_8b10b;

   // configuration toward the character generator
   assign link_cfg.link_identifier = st_ff.link_identifier;
   assign link_cfg.frame_end_char_sel = st_ff.eof_sel[1:0];
   assign link_cfg.link_encoder_enable = st_ff.enc_en;
   assign link_cfg.mode_8b10b = st_ff.mode_8b10b;

   jlps_char_gen u_char_gen (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(link_cfg.tx),
      .ila_mf_idx(ila_mf_idx),
      .ila_did_slot(ila_did_slot),
      .eof_char(eof_char),
      .eof_insert_en(eof_insert_en),
      .ila_did(ila_did),
      .ila_did_valid(ila_did_valid)
   );
endmodule // jlps_regs

//--- jlps_rx_model.sv
/*
 Far-end receiver stand-in: holds sync asserted until told to start,
 then releases sync and later reports the link as up.
 Assumes the bench raises go once lanes would be running.
*/
`timescale 1ns/100ps
module jlps_rx_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   output logic sync_n_pin,
   output logic link_up
);
   logic [2:0] cnt_ff;
   // slow bring-up: sync releases two cycles before link-up, so both reach the slice status together
   always_ff @(posedge clk) begin
      if (!rst_n || !go) cnt_ff <= 3'h0;
      else if (cnt_ff != 3'h5) cnt_ff <= cnt_ff + 3'h1;
   end
   assign sync_n_pin = (cnt_ff >= 3'h3); // low means sync asserted
   assign link_up = (cnt_ff == 3'h5);
endmodule // jlps_rx_model

//--- jlps_regs_sva.sv
/*
 Port-level assertions for the register slice.
 Assumes binding onto jlps_regs, one clock, synchronous reset.
*/
`timescale 1ns/100ps
module jlps_regs_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic sysref_event,
   input wire logic sysref_phase_shift,
   input wire logic [1:0] ila_mf_idx,
   input wire logic ila_did_slot,
   input wire logic irq,
   input wire logic link_encoder_enable,
   input wire logic mode_8b10b,
   input wire logic [7:0] eof_char,
   input wire logic eof_insert_en,
   input wire logic ila_did_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire ev = sysref_event || sysref_phase_shift;
   wire did_hit = ila_did_slot && ila_mf_idx == 2'h1 && link_encoder_enable;
   // comma per select code, reserved code falls back to the default
   function automatic logic [7:0] cm(input logic [1:0] s);
      return s == 2'h1 ? 8'h3C : s == 2'h2 ? 8'hBC : 8'hFC;
   endfunction
   ready_zero_a: assert property (acc |-> pready) else $error("pready missing in access");
   ila_set_a:
      assert property (did_hit |=> ila_did_valid) else $error("device id slot not flagged");
   ila_quiet_a:
      assert property (!did_hit |=> !ila_did_valid) else $error("device id flagged outside slot");
   eof_map_a:
      assert property (wr && paddr == 12'h81C |-> ##2 eof_char == cm($past(pwdata[1:0], 2)))
         else $error("wrong end-of-frame comma");
   eof_legal_a:
      assert property ($past(rst_n) |-> eof_char inside {8'hFC, 8'h3C, 8'hBC}) else $error("illegal comma");
   eof_gate_a:
      assert property (eof_insert_en |-> (link_encoder_enable || $past(link_encoder_enable))
         && (mode_8b10b || $past(mode_8b10b))) else $error("comma inserted outside 8b10b");
   irq_rise_a:
      assert property ($rose(irq) |-> $past(ev) || $past(ev, 2) || $past(wr) || $past(wr, 2))
         else $error("irq without cause");
   irq_fall_a:
      assert property ($fell(irq) && $past(rst_n, 2) |-> $past(wr) || $past(wr, 2))
         else $error("irq dropped without write");
   cov_did_c: cover property (ila_did_valid);
   cov_irq_c: cover property ($rose(irq));
   cov_fall_c: cover property ($fell(irq));
endmodule // jlps_regs_sva

//--- jlps_regs_tb.sv
/*
 Self-checking bench for the register slice with a bench-side model.
 Assumes the receiver stand-in drives sync and link-up.
*/
`timescale 1ns/100ps
module jlps_regs_tb;
   localparam logic [11:0] A_ID = {jlps_pkg::LINK_ID_IDX, 2'h0};
   localparam logic [11:0] A_FC = {jlps_pkg::EOF_SEL_IDX, 2'h0};
   localparam logic [11:0] A_ST = {jlps_pkg::STATUS_IDX, 2'h0};
   localparam logic [11:0] A_CT = {jlps_pkg::CTRL_IDX, 2'h0};
   localparam logic [11:0] A_MK = {jlps_pkg::IMASK_IDX, 2'h0};
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
   logic spl = 0, cpl = 0, sev = 0, sps = 0, slot = 0, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, d0;
   logic [1:0] mf = 0;
   logic [7:0] ec, idd;
   logic pready, pslverr, irq, lee, m8, eie, idv, sync_n, lu;
   int mismatches = 0, checks_done = 0, rl = 0, al = 0, arm = 0, en = 0, up = 0;
   logic [31:0] msk = 0;
   jlps_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_n_pin(sync_n), .serdes_pll_lock_pin(spl), .converter_pll_lock_pin(cpl), .link_up(lu),
      .sysref_event(sev), .sysref_phase_shift(sps), .ila_mf_idx(mf), .ila_did_slot(slot), .irq(irq),
      .link_encoder_enable(lee), .mode_8b10b(m8), .eof_char(ec), .eof_insert_en(eie), .ila_did(idd),
      .ila_did_valid(idv));
   jlps_rx_model far (.clk(clk), .rst_n(rst_n), .go(go), .sync_n_pin(sync_n), .link_up(lu));
   initial forever #50 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer; the extra idle edge keeps drivers from double assigning
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin mismatches++; end_of_test; end
      rd = prdata; e = pslverr; psel <= 0; penable <= 0;
      @(posedge clk);
   endtask
   // write plus model update of sticky flags, arming and mask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1, a, d);
      if (a == A_ST) begin if (d[4]) rl = 0; if (d[3]) al = 0; end
      if (a == A_CT) begin if (!d[0]) arm = 0; else if (!en) arm = 1; en = d[0]; end
      if (a == A_MK) msk = d;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      bus(0, a, 32'h0);
      chk(rd, x);
   endtask
   function automatic logic [31:0] st();
      return {25'h0, up[0], up[0], rl[0], al[0], spl, 1'b0, cpl};
   endfunction
   task automatic pl(input logic ev, input logic ps);
      sev <= ev; sps <= ps;
      @(posedge clk);
      sev <= 0; sps <= 0;
      @(posedge clk);
      if (ps) rl = 1;
      if (ev) begin if (arm && en) al = 1; arm = 0; end
   endtask
   initial begin
      int k;
      void'($urandom(32'h9491561d));
      repeat (16) @(posedge clk);
      rst_n <= 1; spl <= 1;
      repeat (4) @(posedge clk);
      rdc(A_ID, 0);
      rdc(A_FC, 0);
      rdc(A_ST, st());
      $display("reset values done");
      // encoder off while reprogramming
      for (k = 0; k < 4; k++) begin
         d0 = $urandom;
         wr(A_ID, {24'h0, d0[7:0]});
         wr(A_FC, {24'h0, d0[15:8]});
         rdc(A_ID, {24'h0, d0[7:0]});
         rdc(A_FC, {24'h0, d0[15:8]});
      end
      wr(A_ST, 32'hE7);
      rdc(A_ST, st());
      bus(0, 12'h7FC, 32'h0);
      chk({rd[31:1], e}, 32'h1);
      $display("access test done");
      // every select code incl. the reserved one; 0 is the standard pick
      for (k = 0; k < 4; k++) begin
         wr(A_CT, 0);
         wr(A_FC, k);
         wr(A_CT, 3);
         repeat (2) @(posedge clk);
         chk({30'h0, m8, lee}, 32'h3);
         chk(ec, k == 1 ? 8'h3C : k == 2 ? 8'hBC : 8'hFC);
         chk(eie, k != 3);
         wr(A_CT, 1);
         repeat (2) @(posedge clk);
         chk(eie, 0);
      end
      $display("comma test done");
      wr(A_CT, 0);
      d0 = $urandom;
      wr(A_ID, {24'h0, d0[7:0]});
      wr(A_CT, 3);
      for (k = 0; k < 4; k++) begin
         mf <= 2'(k); slot <= 1;
         @(posedge clk);
         slot <= 0;
         // the flag stands one cycle only: look at it mid-cycle
         @(negedge clk);
         chk(idv, k == 1);
         if (k == 1) chk(idd, d0[7:0]);
         @(posedge clk);
      end
      $display("ila test done");
      // second sysref after enable must not set the flag again
      wr(A_MK, 32'h18);
      wr(A_CT, 0);
      wr(A_CT, 1);
      pl(1, 0);
      rdc(A_ST, st());
      wr(A_ST, 32'h08);
      // flag cleared, so a second sysref must leave it low
      pl(1, 0);
      rdc(A_ST, st());
      pl(1, 1);
      @(posedge clk);
      chk(irq, 1);
      rdc(A_ST, st());
      wr(A_ST, 32'h10);
      rdc(A_ST, st());
      pl(1, 0);
      rdc(A_ST, st());
      wr(A_ST, 32'h08);
      @(posedge clk);
      chk(irq, 0);
      wr(A_MK, 0);
      pl(0, 1);
      @(posedge clk);
      chk(irq, 0);
      rdc(A_ST, st());
      $display("flag test done");
      {spl, cpl} <= 2'($urandom);
      go <= 1;
      k = 0;
      do begin @(posedge clk); k++; end while (lu !== 1'b1 && k < 50);
      if (k >= 50) mismatches++;
      up = 1;
      repeat (3) @(posedge clk);
      rdc(A_ST, st());
      $display("link test done");
      end_of_test;
   end
endmodule // jlps_regs_tb
bind jlps_regs jlps_regs_sva sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .sysref_event(sysref_event),
   .sysref_phase_shift(sysref_phase_shift), .ila_mf_idx(ila_mf_idx), .ila_did_slot(ila_did_slot),
   .irq(irq), .link_encoder_enable(link_encoder_enable), .mode_8b10b(mode_8b10b), .eof_char(eof_char),
   .eof_insert_en(eof_insert_en), .ila_did_valid(ila_did_valid));
